// [core/rerc_pkg.sv]
// Constants shared by the real-time counter event routing register bank.
package rerc_pkg;
  localparam int unsigned NUM_MATCH = 4;
  localparam int unsigned NUM_EV = 6;
  localparam int unsigned CHANNEL_INDEX_W = 8;
  localparam int unsigned AW = 10;
  // Word indices of the registers (byte offset divided by four).
  localparam logic [AW-1:0] IDX_EV_STEP = 10'h040;
  localparam logic [AW-1:0] IDX_EV_WRAP = 10'h041;
  localparam logic [AW-1:0] IDX_EV_MATCH0 = 10'h050;
  localparam logic [AW-1:0] IDX_PUB0 = 10'h070;
  localparam logic [AW-1:0] IDX_EVENT_TASK_SHORTCUTS = 10'h080;
  localparam logic [AW-1:0] IDX_INTSET = 10'h0c1;
  localparam logic [AW-1:0] IDX_INTCLR = 10'h0c2;
  localparam logic [AW-1:0] IDX_EVENT_ROUTING_ENABLE = 10'h0d0;
  localparam logic [AW-1:0] IDX_EVTSET = 10'h0d1;
  localparam logic [AW-1:0] IDX_EVTCLR = 10'h0d2;
  localparam logic [AW-1:0] IDX_STEP1 = 10'h001;
  localparam int unsigned ADDR_LSB = 2;
  // Byte addresses, for software and the bench.
  localparam logic [31:0] OFS_PUB0 = 32'h0000_01c0;
  localparam logic [31:0] OFS_EVENT_TASK_SHORTCUTS = 32'h0000_0200;
  localparam logic [31:0] OFS_INTSET = 32'h0000_0304;
  localparam logic [31:0] OFS_INTCLR = 32'h0000_0308;
  localparam logic [31:0] OFS_EVENT_ROUTING_ENABLE = 32'h0000_0340;
  localparam logic [31:0] OFS_EVTSET = 32'h0000_0344;
  localparam logic [31:0] OFS_EVTCLR = 32'h0000_0348;
  // Field positions.
  localparam int unsigned PUB_EN_BIT = 31;
  localparam int unsigned EV_STEP = 0;
  localparam int unsigned EV_WRAP = 1;
  localparam int unsigned EV_MATCH0 = 2;
  localparam int unsigned FLAG_BIT = 0;
  // Reset values.
  localparam logic [NUM_EV-1:0] EV_RST = 6'h00;
  localparam logic [NUM_MATCH-1:0] MATCH_RST = 4'h0;
  localparam logic [CHANNEL_INDEX_W-1:0] CHANNEL_INDEX_RST = 8'h00;
  localparam logic [31:0] WORD_ZERO = 32'h0000_0000;
  // Bus encodings.
  localparam logic [1:0] HRESP_OKAY = 2'h0;
endpackage

// [core/rerc_top.sv]
// AHB-Lite register bank for the counter's event publishing, shortcuts and enables.
//
// Notes on behaviour
// - Each match event has a publish register with an 8-bit channel index.
// - Publish enable bit: 0 blocks, 1 publishes the match on its channel.
// - Per-match shortcut bit makes that match pulse the counter clear task.
// - All shortcuts are off after reset; the shortcut register reads zero.
// - Writing 1 to the step bit of the set register enables its interrupt.
// - Writing 1 to the wrap bit of the set register enables its interrupt.
// - Writing 1 to a match bit of the set register enables its interrupt.
// - Writing 1 to the step bit of the clear register disables its interrupt.
// - Writing 1 to the wrap bit of the clear register disables its interrupt.
// - Writing 1 to a match bit of the clear register disables its interrupt.
// - Routing register has a directly writable step routing bit.
// - Routing register has a directly writable wrap routing bit.
// - Routing register has one directly writable bit per match event.
// - The step event is raised on each counter increment.
// - The wrap event is raised on counter overflow.
// - Match event n is raised when the counter equals compare value n.
// - Routing bits are also set and cleared by writing 1 to set/clear registers.
`timescale 1ns/1ps
module rerc_top
  import rerc_pkg::*;
(
  input wire logic ref_clk_in, // 50 MHz clock.
  input wire logic sys_rst_in, // Asynchronous reset, active high.
  input wire logic hsel_in, // AHB slave select.
  input wire logic [31:0] haddr_in, // AHB address.
  input wire logic [1:0] htrans_in, // AHB transfer type.
  input wire logic hwrite_in, // AHB write.
  input wire logic [2:0] hsize_in, // AHB size, words only.
  input wire logic hready_in, // AHB bus ready.
  input wire logic [31:0] hwdata_in, // AHB write data.
  output logic [31:0] hrdata_out, // AHB read data.
  output logic hreadyout_out, // AHB slave ready.
  output logic [1:0] hresp_out, // AHB response, always OKAY.
  input wire logic counter_step_in, // Counter increment pulse.
  input wire logic counter_wrap_in, // Counter overflow pulse.
  input wire logic [NUM_MATCH-1:0] match_in, // Compare match pulses.
  output logic [NUM_MATCH-1:0] match_publish_out, // Match published pulses.
  output logic [CHANNEL_INDEX_W-1:0] match0_channel_out, // Channel of match 0.
  output logic [CHANNEL_INDEX_W-1:0] match1_channel_out, // Channel of match 1.
  output logic [CHANNEL_INDEX_W-1:0] match2_channel_out, // Channel of match 2.
  output logic [CHANNEL_INDEX_W-1:0] match3_channel_out, // Channel of match 3.
  output logic [NUM_EV-1:0] routed_event_out, // Routed event pulses.
  output logic counter_zero_task_out, // Counter clear task pulse.
  output logic irq_out // Interrupt request.
);

  logic wr_pend_q;
  logic [AW-1:0] wr_idx_q;
  logic [31:0] rdata_q;
  logic [NUM_MATCH-1:0] pub_en_q;
  logic [NUM_MATCH-1:0] pub_en_d;
  logic [CHANNEL_INDEX_W-1:0] pub_ch_q [NUM_MATCH];
  logic [CHANNEL_INDEX_W-1:0] pub_ch_d [NUM_MATCH];
  logic [NUM_MATCH-1:0] event_task_shortcuts_q;
  logic [NUM_MATCH-1:0] event_task_shortcuts_d;
  logic [NUM_EV-1:0] inten_q;
  logic [NUM_EV-1:0] inten_d;
  logic [NUM_EV-1:0] event_routing_enable_q;
  logic [NUM_EV-1:0] event_routing_enable_d;
  logic [NUM_EV-1:0] flags_q;
  logic [NUM_EV-1:0] flags_d;
  logic [NUM_EV-1:0] flag_clr;
  logic [NUM_MATCH-1:0] publish_q;
  logic [NUM_EV-1:0] routed_q;
  logic zero_task_q;
  logic irq_q;
  logic hready_q;
  logic [1:0] resp_q;

  // Address phase capture; every access completes with no wait state.
  wire addr_ok = hsel_in && hready_in && htrans_in[1];
  wire [AW-1:0] a_idx = haddr_in[AW+ADDR_LSB-1:ADDR_LSB];
  wire wr_start = addr_ok && hwrite_in;
  wire rd_start = addr_ok && !hwrite_in;

  wire [NUM_EV-1:0] wv = hwdata_in[NUM_EV-1:0];
  wire [NUM_EV-1:0] ev = {match_in, counter_wrap_in, counter_step_in};
  wire wr_event_task_shortcuts = wr_pend_q && (wr_idx_q == IDX_EVENT_TASK_SHORTCUTS);
  wire wr_intset = wr_pend_q && (wr_idx_q == IDX_INTSET);
  wire wr_intclr = wr_pend_q && (wr_idx_q == IDX_INTCLR);
  wire wr_event_routing_enable = wr_pend_q && (wr_idx_q == IDX_EVENT_ROUTING_ENABLE);
  wire wr_evtset = wr_pend_q && (wr_idx_q == IDX_EVTSET);
  wire wr_evtclr = wr_pend_q && (wr_idx_q == IDX_EVTCLR);

  assign event_task_shortcuts_d = wr_event_task_shortcuts ? hwdata_in[NUM_MATCH-1:0] : event_task_shortcuts_q;
  // One shared vector; ones set or clear, zeros leave bits alone.
  assign inten_d = (inten_q | (wr_intset ? wv : EV_RST))
    & ~(wr_intclr ? wv : EV_RST);
  assign event_routing_enable_d = ((wr_event_routing_enable ? wv : event_routing_enable_q)
    | (wr_evtset ? wv : EV_RST)) & ~(wr_evtclr ? wv : EV_RST);
  // A new event wins over a software clear in the same cycle.
  assign flags_d = (flags_q & ~flag_clr) | ev;

  genvar g;
  generate
    for (g = 0; g < NUM_EV; g++) begin : g_flag
      localparam logic [AW-1:0] FIDX = (g < EV_MATCH0) ? IDX_EV_STEP + AW'(g) :
        IDX_EV_MATCH0 + AW'(g - EV_MATCH0);
      assign flag_clr[g] = wr_pend_q && (wr_idx_q == FIDX) && !hwdata_in[FLAG_BIT];
    end
    for (g = 0; g < NUM_MATCH; g++) begin : g_pub
      wire wr_pub = wr_pend_q && (wr_idx_q == IDX_PUB0 + AW'(g));
      assign pub_en_d[g] = wr_pub ? hwdata_in[PUB_EN_BIT] : pub_en_q[g];
      assign pub_ch_d[g] = wr_pub ? hwdata_in[CHANNEL_INDEX_W-1:0] : pub_ch_q[g];
    end
  endgenerate

  // Read data uses next-state values so a read right after a write sees it.
  wire [AW-1:0] pub_off = a_idx - IDX_PUB0;
  wire rd_pub = (a_idx >= IDX_PUB0) && (pub_off < AW'(NUM_MATCH));
  wire [1:0] pub_sel = pub_off[1:0];
  wire rd_flag_step = (a_idx == IDX_EV_STEP) || (a_idx == IDX_EV_WRAP);
  wire [AW-1:0] mflag_off = a_idx - IDX_EV_MATCH0;
  wire rd_flag_match = (a_idx >= IDX_EV_MATCH0) && (mflag_off < AW'(NUM_MATCH));
  wire [2:0] flag_sel = rd_flag_step ? 3'(a_idx[0]) : 3'(mflag_off[1:0]) + 3'(EV_MATCH0);
  wire [31:0] rd_pub_word = {pub_en_d[pub_sel], 23'h000000, pub_ch_d[pub_sel]};
  wire [31:0] rd_word =
    rd_pub ? rd_pub_word :
    (rd_flag_step || rd_flag_match) ? 32'(flags_d[flag_sel]) :
    (a_idx == IDX_EVENT_TASK_SHORTCUTS) ? 32'(event_task_shortcuts_d) :
    (a_idx == IDX_INTSET || a_idx == IDX_INTCLR) ? 32'(inten_d) :
    (a_idx == IDX_EVENT_ROUTING_ENABLE || a_idx == IDX_EVTSET || a_idx == IDX_EVTCLR) ? 32'(event_routing_enable_d) :
    WORD_ZERO;

  always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      wr_pend_q <= 1'b0;
      wr_idx_q <= '0;
      rdata_q <= WORD_ZERO;
    end else begin
      wr_pend_q <= wr_start;
      wr_idx_q <= wr_start ? a_idx : wr_idx_q;
      rdata_q <= rd_start ? rd_word : rdata_q;
    end
  end

  always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      pub_en_q <= MATCH_RST;
      event_task_shortcuts_q <= MATCH_RST;
      inten_q <= EV_RST;
      event_routing_enable_q <= EV_RST;
      flags_q <= EV_RST;
    end else begin
      pub_en_q <= pub_en_d;
      event_task_shortcuts_q <= event_task_shortcuts_d;
      inten_q <= inten_d;
      event_routing_enable_q <= event_routing_enable_d;
      flags_q <= flags_d;
    end
  end

  always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      for (int i = 0; i < NUM_MATCH; i++) begin
        pub_ch_q[i] <= CHANNEL_INDEX_RST;
      end
    end else begin
      pub_ch_q <= pub_ch_d;
    end
  end

  always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      publish_q <= MATCH_RST;
      routed_q <= EV_RST;
      zero_task_q <= 1'b0;
      irq_q <= 1'b0;
    end else begin
      publish_q <= match_in & pub_en_q;
      routed_q <= ev & event_routing_enable_q;
      zero_task_q <= |(match_in & event_task_shortcuts_q);
      irq_q <= |(flags_q & inten_q);
    end
  end

  // Bus status comes from flops; the slave never stalls and never signals an error.
  always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      hready_q <= 1'b1;
      resp_q <= HRESP_OKAY;
    end else begin
      hready_q <= 1'b1;
      resp_q <= HRESP_OKAY;
    end
  end

  assign hrdata_out = rdata_q;
  assign hreadyout_out = hready_q;
  assign hresp_out = resp_q;
  assign match_publish_out = publish_q;
  assign match0_channel_out = pub_ch_q[0];
  assign match1_channel_out = pub_ch_q[1];
  assign match2_channel_out = pub_ch_q[2];
  assign match3_channel_out = pub_ch_q[3];
  assign routed_event_out = routed_q;
  assign counter_zero_task_out = zero_task_q;
  assign irq_out = irq_q;

  default clocking cb @(posedge ref_clk_in);
  endclocking
  default disable iff (sys_rst_in);

  sequence s_wr(logic [AW-1:0] idx);
    addr_ok && hwrite_in && (a_idx == idx);
  endsequence

  sequence s_rd(logic [AW-1:0] idx);
    addr_ok && !hwrite_in && (a_idx == idx);
  endsequence

  property p_pub_ch;
    s_rd(IDX_PUB0) ##1 1'b1 |-> hrdata_out[CHANNEL_INDEX_W-1:0] == pub_ch_q[0];
  endproperty
  a_pub_ch: assert property (p_pub_ch) else $error("publish channel readback wrong");

  property p_publish;
    match_in[1] |=> match_publish_out[1] == $past(pub_en_q[1]);
  endproperty
  a_publish: assert property (p_publish) else $error("publish pulse wrong");

  property p_short;
    (|(match_in & event_task_shortcuts_q)) |=> counter_zero_task_out;
  endproperty
  a_short: assert property (p_short) else $error("shortcut did not clear counter");

  property p_short_off;
    (match_in & event_task_shortcuts_q) == MATCH_RST |=> !counter_zero_task_out;
  endproperty
  a_short_off: assert property (p_short_off) else $error("clear task without shortcut");

  property p_short_rst;
    $fell(sys_rst_in) |-> event_task_shortcuts_q == MATCH_RST && !counter_zero_task_out;
  endproperty
  a_short_rst: assert property (@(posedge ref_clk_in) p_short_rst)
    else $error("shortcuts not zero after reset");

  property p_intset;
    s_wr(IDX_INTSET) ##1 hwdata_in[EV_STEP] |=> inten_q[EV_STEP];
  endproperty
  a_intset: assert property (p_intset) else $error("interrupt set failed");

  property p_intclr;
    s_wr(IDX_INTCLR) ##1 hwdata_in[EV_WRAP] |=> !inten_q[EV_WRAP];
  endproperty
  a_intclr: assert property (p_intclr) else $error("interrupt clear failed");

  property p_intzero;
    s_wr(IDX_INTSET) ##1 (hwdata_in[NUM_EV-1:0] == EV_RST) |=> $stable(inten_q);
  endproperty
  a_intzero: assert property (p_intzero) else $error("zero write changed enables");

  property p_event_routing_enable;
    s_wr(IDX_EVENT_ROUTING_ENABLE) ##1 1'b1 |=> event_routing_enable_q == $past(hwdata_in[NUM_EV-1:0]);
  endproperty
  a_event_routing_enable: assert property (p_event_routing_enable) else $error("routing write lost");

  property p_evtset;
    s_wr(IDX_EVTSET) ##1 hwdata_in[EV_WRAP] |=> event_routing_enable_q[EV_WRAP]
      ##1 (routed_event_out[EV_WRAP] || !$past(counter_wrap_in));
  endproperty
  a_evtset: assert property (p_evtset) else $error("routing set failed");

  property p_step_flag;
    counter_step_in |=> flags_q[EV_STEP];
  endproperty
  a_step_flag: assert property (p_step_flag) else $error("step flag lost");

  property p_irq;
    (|(flags_q & inten_q)) |=> irq_out;
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt not raised");

  property p_publish_all;
    1'b1 |=> match_publish_out == $past(match_in & pub_en_q);
  endproperty
  a_publish_all: assert property (p_publish_all) else $error("publish pulses wrong");

  property p_pub_rd;
    s_rd(IDX_PUB0) ##1 1'b1 |-> hrdata_out[PUB_EN_BIT] == pub_en_q[0];
  endproperty
  a_pub_rd: assert property (p_pub_rd) else $error("publish enable readback wrong");

  property p_short_rd;
    s_rd(IDX_EVENT_TASK_SHORTCUTS) ##1 1'b1 |-> hrdata_out == 32'(event_task_shortcuts_q);
  endproperty
  a_short_rd: assert property (p_short_rd) else $error("shortcut readback wrong");

  property p_intset_wrap;
    s_wr(IDX_INTSET) ##1 hwdata_in[EV_WRAP] |=> inten_q[EV_WRAP];
  endproperty
  a_intset_wrap: assert property (p_intset_wrap) else $error("wrap enable not set");

  property p_intset_all;
    s_wr(IDX_INTSET) ##1 1'b1 |=> (inten_q & $past(wv)) == $past(wv);
  endproperty
  a_intset_all: assert property (p_intset_all) else $error("match enable not set");

  property p_intclr_step;
    s_wr(IDX_INTCLR) ##1 hwdata_in[EV_STEP] |=> !inten_q[EV_STEP];
  endproperty
  a_intclr_step: assert property (p_intclr_step) else $error("step enable not cleared");

  property p_intclr_all;
    s_wr(IDX_INTCLR) ##1 1'b1 |=> (inten_q & $past(wv)) == EV_RST;
  endproperty
  a_intclr_all: assert property (p_intclr_all) else $error("match enable not cleared");

  property p_int_rd;
    s_rd(IDX_INTCLR) ##1 1'b1 |-> hrdata_out == 32'(inten_q);
  endproperty
  a_int_rd: assert property (p_int_rd) else $error("enable readback wrong");

  property p_route_step;
    counter_step_in |=> routed_event_out[EV_STEP] == $past(event_routing_enable_q[EV_STEP]);
  endproperty
  a_route_step: assert property (p_route_step) else $error("step routing wrong");

  property p_route_wrap;
    counter_wrap_in |=> routed_event_out[EV_WRAP] == $past(event_routing_enable_q[EV_WRAP]);
  endproperty
  a_route_wrap: assert property (p_route_wrap) else $error("wrap routing wrong");

  property p_route_match;
    1'b1 |=> routed_event_out[NUM_EV-1:EV_MATCH0]
      == $past(match_in & event_routing_enable_q[NUM_EV-1:EV_MATCH0]);
  endproperty
  a_route_match: assert property (p_route_match) else $error("match routing wrong");

  property p_wrap_flag;
    counter_wrap_in |=> flags_q[EV_WRAP];
  endproperty
  a_wrap_flag: assert property (p_wrap_flag) else $error("wrap flag lost");

  property p_match_flag;
    match_in[NUM_MATCH-1] |=> flags_q[NUM_EV-1];
  endproperty
  a_match_flag: assert property (p_match_flag) else $error("match flag lost");

  property p_evtclr;
    s_wr(IDX_EVTCLR) ##1 1'b1 |=> (event_routing_enable_q & $past(wv)) == EV_RST;
  endproperty
  a_evtclr: assert property (p_evtclr) else $error("routing clear failed");

  property p_clrzero;
    s_wr(IDX_INTCLR) ##1 (hwdata_in[NUM_EV-1:0] == EV_RST) |=> $stable(inten_q);
  endproperty
  a_clrzero: assert property (p_clrzero) else $error("zero clear changed enables");

  property p_irq_low;
    (flags_q & inten_q) == EV_RST |=> !irq_out;
  endproperty
  a_irq_low: assert property (p_irq_low) else $error("interrupt raised without cause");

endmodule

// [tb/rerc_evt_model.sv]
// Far-side model: raises counter events and catches the pulses sent back.
`timescale 1ns/1ps
module rerc_evt_model (
  input wire logic clk_in, // Clock.
  input wire logic [5:0] fire_in, // Events to raise this cycle.
  output logic step_out, // Counter increment pulse.
  output logic wrap_out, // Counter overflow pulse.
  output logic [3:0] match_out, // Compare match pulses.
  input wire logic [3:0] pub_in, // Published matches.
  input wire logic [5:0] routed_in, // Routed events.
  input wire logic zero_in, // Counter clear task.
  output logic [10:0] seen_out // Pulses caught since the last raise.
);
  assign step_out = fire_in[0];
  assign wrap_out = fire_in[1];
  assign match_out = fire_in[5:2];
  always_ff @(posedge clk_in) begin
    if (|fire_in) begin
      seen_out <= 11'h000;
    end else begin
      seen_out <= seen_out | {zero_in, pub_in, routed_in};
    end
  end
endmodule

// [tb/rtc_event_routing_config_bench.sv]
// Self-checking bench for the counter event routing register bank.
`timescale 1ns/1ps
module rtc_event_routing_config_bench
  import rerc_pkg::*;
;
  logic clk, rst, hwrite, hready, irq, zero, step, wrap;
  logic [1:0] htrans, hresp;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [5:0] fire, routed;
  logic [3:0] pub, match;
  logic [10:0] seen;
  logic [7:0] ch [4];
  // Event flag registers of the step, wrap and last match events.
  localparam logic [31:0] OFS_EV_STEP = 32'h0000_0100;
  localparam logic [31:0] OFS_EV_WRAP = 32'h0000_0104;
  localparam logic [31:0] OFS_EV_MATCH3 = 32'h0000_014c;
  int err_count = 0;
  int n_checks = 0;
  rerc_top rerc_top_inst (.ref_clk_in(clk), .sys_rst_in(rst), .hsel_in(1'b1), .haddr_in(haddr),
    .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(3'h2), .hready_in(hready),
    .hwdata_in(hwdata), .hrdata_out(hrdata), .hreadyout_out(hready), .hresp_out(hresp),
    .counter_step_in(step), .counter_wrap_in(wrap), .match_in(match), .match_publish_out(pub),
    .match0_channel_out(ch[0]), .match1_channel_out(ch[1]), .match2_channel_out(ch[2]),
    .match3_channel_out(ch[3]), .routed_event_out(routed), .counter_zero_task_out(zero),
    .irq_out(irq));
  rerc_evt_model rerc_evt_model_inst (.clk_in(clk), .fire_in(fire), .step_out(step),
    .wrap_out(wrap), .match_out(match), .pub_in(pub), .routed_in(routed), .zero_in(zero),
    .seen_out(seen));
  task automatic test_done();
    $display("checks %0d errors %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] wd);
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    do begin
      @(posedge clk);
    end while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= wd;
    do begin
      @(posedge clk);
    end while (hready !== 1'b1);
    rd = hrdata;
  endtask
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask
  task automatic rdc(input logic [31:0] a, input logic [31:0] e);
    bus(1'b0, a, WORD_ZERO);
    chk(rd, e);
  endtask
  // Raises events for one cycle and compares what came back two edges later.
  task automatic fire_chk(input logic [5:0] ev, input logic [10:0] e);
    fire <= ev;
    @(posedge clk);
    fire <= 6'h00;
    repeat (2) @(posedge clk);
    chk({21'h0, seen}, {21'h0, e});
  endtask
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  initial begin
    repeat (5000) @(posedge clk);
    err_count++;
    test_done();
  end
  initial begin
    rst = 1'b1;
    htrans = 2'h0;
    haddr = WORD_ZERO;
    hwrite = 1'b0;
    hwdata = WORD_ZERO;
    fire = 6'h00;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    for (int i = 0; i < 4; i++) begin
      rdc(OFS_PUB0 + 32'(4 * i), WORD_ZERO);
    end
    rdc(OFS_EVENT_TASK_SHORTCUTS, WORD_ZERO);
    rdc(OFS_INTSET, WORD_ZERO);
    rdc(OFS_INTCLR, WORD_ZERO);
    rdc(OFS_EVENT_ROUTING_ENABLE, WORD_ZERO);
    chk({30'h0, hresp}, {30'h0, HRESP_OKAY});
    wr(32'h0000_03fc, 32'hffff_ffff);
    rdc(32'h0000_03fc, WORD_ZERO);
    wr(OFS_INTSET, 32'h0000_003f);
    rdc(OFS_INTSET, 32'h0000_003f);
    wr(OFS_INTCLR, 32'h0000_003d);
    rdc(OFS_INTCLR, 32'h0000_0002);
    wr(OFS_INTSET, WORD_ZERO);
    wr(OFS_INTCLR, WORD_ZERO);
    rdc(OFS_INTSET, 32'h0000_0002);
    fire_chk(6'h01, 11'h000);
    rdc(OFS_EV_STEP, 32'h0000_0001);
    chk({31'h0, irq}, 32'h0);
    fire_chk(6'h02, 11'h000);
    chk({31'h0, irq}, 32'h1);
    wr(OFS_EV_WRAP, WORD_ZERO);
    repeat (3) @(posedge clk);
    chk({31'h0, irq}, 32'h0);
    rdc(OFS_EV_WRAP, WORD_ZERO);
    for (int i = 0; i < 4; i++) begin
      wr(OFS_PUB0 + 32'(4 * i), {i[0], 23'h0, 8'hff - 8'(i * 85)});
    end
    for (int i = 0; i < 4; i++) begin
      rdc(OFS_PUB0 + 32'(4 * i), {i[0], 23'h0, 8'hff - 8'(i * 85)});
      chk({24'h0, ch[i]}, {24'h0, 8'hff - 8'(i * 85)});
    end
    fire_chk(6'h3c, 11'h280);
    rdc(OFS_EV_MATCH3, 32'h0000_0001);
    wr(OFS_EVENT_TASK_SHORTCUTS, 32'h0000_0004);
    rdc(OFS_EVENT_TASK_SHORTCUTS, 32'h0000_0004);
    fire_chk(6'h08, 11'h080);
    fire_chk(6'h10, 11'h400);
    wr(OFS_EVENT_ROUTING_ENABLE, 32'h0000_0029);
    rdc(OFS_EVENT_ROUTING_ENABLE, 32'h0000_0029);
    fire_chk(6'h3f, 11'h6a9);
    wr(OFS_EVTSET, 32'h0000_0002);
    rdc(OFS_EVENT_ROUTING_ENABLE, 32'h0000_002b);
    wr(OFS_EVTCLR, 32'h0000_0021);
    rdc(OFS_EVENT_ROUTING_ENABLE, 32'h0000_000a);
    fire_chk(6'h3f, 11'h68a);
    chk({31'h0, irq}, 32'h1);
    wr(OFS_INTCLR, 32'h0000_0002);
    rdc(OFS_INTSET, WORD_ZERO);
    chk({31'h0, irq}, 32'h0);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rdc(OFS_EVENT_TASK_SHORTCUTS, WORD_ZERO);
    rdc(OFS_PUB0 + 32'h0000_0004, WORD_ZERO);
    rdc(OFS_EVENT_ROUTING_ENABLE, WORD_ZERO);
    test_done();
  end
endmodule
